// ===== rtl/isic_ctrl.v
// Input and scheduled interrupt controller with APB command registers
// Operation
// - Inputs latch pending even while masked
// - Clear command is type 000 function 001
// - Set data bit clears that input's latch
// - Read-mask returns masked inputs as ones
// - Interval BCD 0001-9999 times time unit
// - First-time BCD 0001-9999 times time unit
// - Setup word bit selects 1/10 ms
// - Mask-all and unmask-all ignore data word
// - Undefined selectors set error, no action; mask-all and unmask-all accept any type
// - Non-BCD or out-of-range data sets error
// - All inputs masked after reset
// - Type 000 function 000 sets input masks
// - Unmasked pending input requests service at once
// - Scheduled interrupt disabled, interval zero, at reset
// - Setup bit holds input service until CPU idle; scheduled requests are not held
`timescale 1ns/10ps
`include "isic_consts.vh"
module isic_ctrl (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [7:0] int_in,
  input wire cpu_busy,
  output reg [7:0] input_req_ff,
  output reg sched_req_ff,
  output reg error_flag_ff
);
  // Checks every digit of a 16-bit word for BCD
  // Used by the time-value check; a nibble above 9 makes the word
  // unusable as a count, so the command is refused instead.
  function is_bcd;
    input [15:0] v;
    begin
      is_bcd = (v[3:0] < 4'hA) && (v[7:4] < 4'hA) &&
        (v[11:8] < 4'hA) && (v[15:12] < 4'hA);
    end
  endfunction

  // Register state
  // Input side: masks, global mask and the pending latches
  reg [7:0] mask_ff; // One bit per input, 1 = masked
  reg mask_all_ff; // Global mask from the mask-all command
  reg [7:0] pend_ff; // Recorded arrivals not yet serviced
  // Command data and read-back
  reg [15:0] data_ff; // Operand word for the next command
  reg [15:0] result_ff; // Answer of the last read command
  // Scheduled interrupt settings
  reg [15:0] interval_ff; // BCD period in time units
  reg [15:0] first_ff; // BCD delay to the first event
  reg [1:0] setup_ff; // Time unit and wait-for-idle bits
  reg sched_evt_ff; // Counter expiry, one cycle
  reg first_wait_ff; // A first-time value has been loaded
  // Time unit prescaler
  reg [3:0] unit_cnt_ff; // Milliseconds within a 10 ms unit
  reg unit_en_ff; // One pulse per time unit
  // Previous input levels; reset to the idle low level so that
  // no false arrival follows reset
  reg [7:0] int_in_d_ff;

  // Scheduler state machine
  localparam ST_OFF = 2'h0;
  localparam ST_FIRST = 2'h1;
  localparam ST_RUN = 2'h2;
  reg [1:0] st_ff;
  reg [1:0] nxt_st;

  wire ms_tick;
  wire cnt_zero;
  wire [15:0] cnt_val;
  reg cnt_load;
  reg [15:0] cnt_load_val;

  // APB phases; the slave answers in the first access cycle
  // Writes act at the access edge, which is also the edge where
  // pready is high, so no write lands before the master sees it
  wire apb_acc = psel && penable;
  wire apb_wr = apb_acc && pwrite;
  wire cmd_wr = apb_wr && (paddr == `ISIC_OFF_CMD);
  wire [11:0] cmd_n = pwdata[`ISIC_CMD_N_LSB +: 12];
  wire [11:0] cmd_c = pwdata[`ISIC_CMD_C_LSB +: 12];
  wire addr_ok = (paddr == `ISIC_OFF_CMD) ||
    (paddr == `ISIC_OFF_DATA) || (paddr == `ISIC_OFF_RESULT) ||
    (paddr == `ISIC_OFF_STATUS) || (paddr == `ISIC_OFF_SETUP) ||
    (paddr == `ISIC_OFF_PEND) || (paddr == `ISIC_OFF_SERVICE);

  // Mask-all and unmask-all depend on the function code only;
  // the type selector is not checked for them
  // Command decode
  wire c_all = (cmd_c == `ISIC_C_MASK_ALL) ||
    (cmd_c == `ISIC_C_UNMASK_ALL);
  wire n_in = (cmd_n == `ISIC_N_INPUT);
  wire n_sc = (cmd_n == `ISIC_N_SCHED);
  wire c_lo = (cmd_c == `ISIC_C_000) || (cmd_c == `ISIC_C_001) ||
    (cmd_c == `ISIC_C_002);
  wire sel_ok = c_all || ((n_in || n_sc) && c_lo);
  // Time values must be BCD and nonzero
  wire needs_time = n_sc && !c_all &&
    ((cmd_c == `ISIC_C_000) || (cmd_c == `ISIC_C_001));
  wire data_ok = !needs_time ||
    (is_bcd(data_ff) && (data_ff != 16'h0000));
  wire do_cmd = cmd_wr && sel_ok && data_ok;
  wire do_in = do_cmd && n_in && !c_all;
  wire do_sc = do_cmd && n_sc && !c_all;
  // Executed command strobes, one per function
  wire do_mask = do_in && (cmd_c == `ISIC_C_000);
  wire do_clear = do_in && (cmd_c == `ISIC_C_001);
  wire do_rdmask = do_in && (cmd_c == `ISIC_C_002);
  wire do_interval = do_sc && (cmd_c == `ISIC_C_000);
  wire do_first = do_sc && (cmd_c == `ISIC_C_001);
  wire do_rdint = do_sc && (cmd_c == `ISIC_C_002);
  wire do_mask_all = do_cmd && (cmd_c == `ISIC_C_MASK_ALL);
  wire do_unmask_all = do_cmd && (cmd_c == `ISIC_C_UNMASK_ALL);
  // Latches to drop on a clear; zero bits keep theirs
  wire [7:0] clr_bits = do_clear ? data_ff[7:0] : 8'h00;
  // Rising edges seen this cycle
  wire [7:0] rise = int_in & ~int_in_d_ff;

  // Millisecond base tick
  // Fixed 1 ms base; every slower rate is an enable from it
  isic_tick #(
    .TICK_CYC(`ISIC_TICK_CYC)
  ) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .tick_ff(ms_tick)
  );

  // Scheduled interval counter in BCD units
  // Loads win over steps, so a new first time restarts cleanly
  isic_bcd_dec u_cnt (
    .pclk(pclk),
    .presetn(presetn),
    .load(cnt_load),
    .load_val(cnt_load_val),
    .step(unit_en_ff),
    .cnt_ff(cnt_val),
    .zero(cnt_zero)
  );

  // The 10 ms count only moves on a tick, so a unit change
  // takes effect from the next millisecond
  // Time unit prescaler, 1 ms or 10 ms
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_cnt_ff <= 4'h0;
      unit_en_ff <= 1'b0;
    end else if (ms_tick) begin
      if (!setup_ff[`ISIC_SETUP_UNIT_BIT] ||
          unit_cnt_ff == `ISIC_UNIT_LAST) begin
        unit_cnt_ff <= 4'h0;
        unit_en_ff <= 1'b1;
      end else begin
        unit_cnt_ff <= unit_cnt_ff + 4'h1;
        unit_en_ff <= 1'b0;
      end
    end else begin
      unit_en_ff <= 1'b0;
    end
  end

  // Reload on the last unit rather than at zero, so that the
  // period is exactly the programmed number of units
  // Scheduler next state and counter reloads
  always @* begin
    nxt_st = st_ff;
    cnt_load = 1'b0;
    cnt_load_val = first_ff;
    case (st_ff)
      ST_OFF: begin
        if (do_interval) begin
          nxt_st = ST_FIRST;
          cnt_load = 1'b1;
          // Without a first time, the delay is the new interval value
          cnt_load_val = first_wait_ff ? first_ff : data_ff;
        end
      end
      ST_FIRST, ST_RUN: begin
        if (do_first) begin
          nxt_st = ST_FIRST;
          cnt_load = 1'b1;
          cnt_load_val = data_ff;
        end else if (unit_en_ff && cnt_val == 16'h0001) begin
          nxt_st = ST_RUN;
          cnt_load = 1'b1;
          cnt_load_val = interval_ff;
        end
      end
      default: begin
        nxt_st = ST_OFF;
      end
    endcase
  end

  // Scheduler registers and event generation
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= ST_OFF;
      interval_ff <= `ISIC_INTERVAL_RST;
      first_ff <= 16'h0000;
      first_wait_ff <= 1'b0;
      sched_evt_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      // A new interval while running applies at the next reload
      if (do_interval) begin
        interval_ff <= data_ff;
      end
      if (do_first) begin
        first_ff <= data_ff;
        first_wait_ff <= 1'b1;
      end
      // Counter reaches its last unit: one scheduled event
      sched_evt_ff <= (st_ff != ST_OFF) && !cnt_zero &&
        unit_en_ff && (cnt_val == 16'h0001) &&
        !do_first;
    end
  end

  // An arrival in the cycle of its clear or of its service pulse
  // is kept, so no edge is ever lost
  // Input latching, masking and clearing
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_ff <= `ISIC_MASK_RST;
      mask_all_ff <= 1'b0;
      pend_ff <= 8'h00;
      int_in_d_ff <= 8'h00;
    end else begin
      int_in_d_ff <= int_in;
      // Rising edges latch regardless of mask; set wins
      pend_ff <= (pend_ff & ~clr_bits & ~input_req_ff) | rise;
      if (do_mask) begin
        mask_ff <= data_ff[7:0];
      end
      // Global commands ignore the data word
      if (do_mask_all) begin
        mask_all_ff <= 1'b1;
      end else if (do_unmask_all) begin
        mask_all_ff <= 1'b0;
      end
    end
  end

  // Service requests toward the CPU
  // A request pulse clears its own latch on the next edge, so each
  // arrival is serviced once; while the CPU holds off, the latch
  // stays set and the request follows once it is idle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_req_ff <= 8'h00;
      sched_req_ff <= 1'b0;
    end else begin
      // Issue immediately unless held by busy CPU
      // Optional wait for current work to finish
      if (setup_ff[`ISIC_SETUP_WAIT_BIT] && cpu_busy) begin
        input_req_ff <= 8'h00;
      end else begin
        input_req_ff <= pend_ff & ~input_req_ff & ~mask_ff &
          {8{!mask_all_ff}};
      end
      sched_req_ff <= sched_evt_ff;
    end
  end

  // Setup bits act at once; a unit change in mid-period stretches
  // or shortens only that period
  // APB register writes, results and error flag
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_ff <= 16'h0000;
      result_ff <= 16'h0000;
      setup_ff <= `ISIC_SETUP_RST;
      error_flag_ff <= 1'b0;
    end else begin
      if (apb_wr && paddr == `ISIC_OFF_DATA) begin
        data_ff <= pwdata[15:0];
      end
      if (apb_wr && paddr == `ISIC_OFF_SETUP) begin
        setup_ff <= pwdata[1:0];
      end
      if (cmd_wr) begin
        error_flag_ff <= !(sel_ok && data_ok);
      end
      if (do_rdmask) begin
        result_ff <= {8'h00, mask_ff | {8{mask_all_ff}}};
      end
      if (do_rdint) begin
        result_ff <= interval_ff;
      end
    end
  end

  // APB response: zero wait states, error on unmapped address
  // Read data is registered in the setup cycle so that it stands,
  // settled, through the one access cycle in which pready is high
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      prdata <= 32'h00000000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `ISIC_OFF_DATA: prdata <= {16'h0000, data_ff};
          `ISIC_OFF_RESULT: prdata <= {16'h0000, result_ff};
          `ISIC_OFF_STATUS: prdata <= {28'h0000000, mask_all_ff,
            st_ff != ST_OFF, first_wait_ff, error_flag_ff};
          `ISIC_OFF_SETUP: prdata <= {30'h00000000, setup_ff};
          `ISIC_OFF_PEND: prdata <= {16'h0000, mask_ff, pend_ff};
          `ISIC_OFF_SERVICE: prdata <= {16'h0000, cnt_val};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

// ===== include/isic_consts.vh
// Constants for the input and scheduled interrupt controller
`ifndef ISIC_CONSTS_VH
`define ISIC_CONSTS_VH
// Register byte offsets
`define ISIC_OFF_CMD 12'h000
`define ISIC_OFF_DATA 12'h004
`define ISIC_OFF_RESULT 12'h008
`define ISIC_OFF_STATUS 12'h00C
`define ISIC_OFF_SETUP 12'h010
`define ISIC_OFF_PEND 12'h014
`define ISIC_OFF_SERVICE 12'h018
// Command register fields: type in [11:0], function in [27:16]
`define ISIC_CMD_N_LSB 0
`define ISIC_CMD_C_LSB 16
// Selector codes, written as BCD digits
`define ISIC_N_INPUT 12'h000
`define ISIC_N_SCHED 12'h004
`define ISIC_C_000 12'h000
`define ISIC_C_001 12'h001
`define ISIC_C_002 12'h002
`define ISIC_C_MASK_ALL 12'h100
`define ISIC_C_UNMASK_ALL 12'h200
// Setup register bits
`define ISIC_SETUP_UNIT_BIT 0
`define ISIC_SETUP_WAIT_BIT 1
// Reset values
`define ISIC_MASK_RST 8'hFF
`define ISIC_INTERVAL_RST 16'h0000
`define ISIC_SETUP_RST 2'h0
// Timing: clock in MHz, base tick of 1 ms
`define ISIC_CLK_MHZ 125
`define ISIC_TICK_US 1000
`define ISIC_TICK_CYC 17'h1E848
// Last millisecond count inside a 10 ms unit
`define ISIC_UNIT_LAST 4'h9
`endif

// ===== rtl/isic_tick.v
// Millisecond tick divider producing a one-cycle enable pulse
`timescale 1ns/10ps
module isic_tick #(
  parameter [16:0] TICK_CYC = 17'h1E848
) (
  input wire pclk,
  input wire presetn,
  output reg tick_ff
);
  // Cycle counter for one millisecond
  reg [16:0] cnt_ff;
  wire [16:0] last = TICK_CYC - 17'h00001;

  // Count and pulse once per period
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 17'h00000;
      tick_ff <= 1'b0;
    end else if (cnt_ff == last) begin
      cnt_ff <= 17'h00000;
      tick_ff <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 17'h00001;
      tick_ff <= 1'b0;
    end
  end
endmodule

// ===== rtl/isic_bcd_dec.v
// BCD down counter for the scheduled interrupt, one step per enable
`timescale 1ns/10ps
module isic_bcd_dec (
  input wire pclk,
  input wire presetn,
  input wire load,
  input wire [15:0] load_val,
  input wire step,
  output reg [15:0] cnt_ff,
  output wire zero
);
  wire [15:0] nxt_cnt;
  // Per-digit borrow chain
  wire [4:0] borrow;
  assign borrow[0] = 1'b1;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : dig
      wire [3:0] d = cnt_ff[4*g +: 4];
      assign nxt_cnt[4*g +: 4] = borrow[g] ?
        ((d == 4'h0) ? 4'h9 : d - 4'h1) : d;
      assign borrow[g+1] = borrow[g] & (d == 4'h0);
    end
  endgenerate
  assign zero = (cnt_ff == 16'h0000);

  // Load wins over a step in the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 16'h0000;
    end else if (load) begin
      cnt_ff <= load_val;
    end else if (step && !zero) begin
      cnt_ff <= nxt_cnt;
    end
  end
endmodule

// ===== bench/isic_chk.sv
// Port checker for the interrupt controller
`timescale 1ns/10ps
module isic_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] input_req_ff,
  input wire logic sched_req_ff,
  input wire logic error_flag_ff
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Selector word written at its access edge
  wire cmd_wr = psel && penable && pwrite && paddr == 12'h000;
  wire [11:0] sel_n = pwdata[11:0];
  wire [11:0] sel_c = pwdata[27:16];
  // Set once software has touched the timer selector
  logic sched_cmd_ff;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sched_cmd_ff <= 1'b0;
    end else if (cmd_wr && sel_n == 12'h004) begin
      sched_cmd_ff <= 1'b1;
    end
  end
  ready_in_access_a: assert property (psel && !penable |=> pready)
    else $error("no ready in access cycle");
  ready_single_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  slverr_with_ready_a: assert property (pslverr |-> pready)
    else $error("slave error without ready");
  err_bad_type_a: assert property (
    cmd_wr && sel_n != 12'h000 && sel_n != 12'h004 &&
    sel_c != 12'h100 && sel_c != 12'h200 |=> error_flag_ff)
    else $error("bad type selector accepted");
  err_only_cmd_a: assert property (
    !$stable(error_flag_ff) |-> $past(cmd_wr))
    else $error("error flag moved without command");
  input_cmd_ok_a: assert property (
    cmd_wr && sel_n == 12'h000 && sel_c <= 12'h002 |=> !error_flag_ff)
    else $error("valid input command flagged");
  all_mask_ok_a: assert property (
    cmd_wr && (sel_c == 12'h100 || sel_c == 12'h200) |=> !error_flag_ff)
    else $error("mask-all command flagged");
  req_pulse_a: assert property (
    (input_req_ff & $past(input_req_ff)) == 8'h00)
    else $error("input request held two cycles");
  sched_idle_a: assert property (sched_req_ff |-> sched_cmd_ff)
    else $error("scheduled event never programmed");
  cover property (cmd_wr && error_flag_ff == 1'b0);
  cover property (input_req_ff != 8'h00);
  cover property (pslverr);
endmodule

bind isic_ctrl isic_chk isic_chk_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .input_req_ff(input_req_ff), .sched_req_ff(sched_req_ff),
  .error_flag_ff(error_flag_ff));

// ===== bench/isic_int_src.sv
// Model of the external interrupt lines
`timescale 1ns/10ps
module isic_int_src (
  input wire logic pclk,
  input wire logic [7:0] trig,
  output logic [7:0] int_in
);
  // Previous request; lines stay up two cycles so no edge is lost
  logic [7:0] last_ff = 8'h00;
  always @(posedge pclk) begin
    last_ff <= trig;
    int_in <= trig | last_ff;
  end
endmodule

// ===== bench/isic_ctrl_tb.sv
// Self-checking bench for the interrupt controller
`timescale 1ns/10ps
module isic_ctrl_tb;
  logic pclk, presetn, psel, penable, pwrite, cpu_busy, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] int_in, trig, input_req_ff, seen;
  logic sched_req_ff, error_flag_ff, clr, err, sched_any;
  int n_mismatch = 0;
  int checked = 0;
  isic_ctrl isic_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .int_in(int_in),
    .cpu_busy(cpu_busy), .input_req_ff(input_req_ff),
    .sched_req_ff(sched_req_ff), .error_flag_ff(error_flag_ff));
  isic_int_src isic_int_src_i (.pclk(pclk), .trig(trig), .int_in(int_in));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // Requests collected since the last arrival pulse
  always @(posedge pclk) seen <= clr ? 8'h00 : seen | input_req_ff;
  // Any scheduled event since reset
  always @(posedge pclk)
    sched_any <= presetn ? (sched_any | sched_req_ff) : 1'b0;
  task automatic chk(input string nm, input logic [15:0] s, e);
    checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task complete_run;
    if (n_mismatch == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // One APB transfer; the wait on pready has no fixed length
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Data word first, then selectors; flag read once settled
  task automatic cmd(input logic [11:0] n, c, input logic [15:0] d,
      input logic ex);
    apb(1'b1, 12'h004, {16'h0000, d});
    apb(1'b1, 12'h000, {4'h0, c, 4'h0, n});
    #1;
    chk("error_flag", 16'(error_flag_ff), 16'(ex));
  endtask
  task automatic rdres(input string nm, input logic [11:0] n,
      input logic [15:0] e);
    cmd(n, 12'h002, 16'h0000, 1'b0);
    apb(1'b0, 12'h008, 32'h0);
    chk(nm, rd[15:0], e);
  endtask
  // Arrival pulse; the margin covers the two-cycle request path
  task automatic fire(input logic [7:0] p);
    @(posedge pclk);
    clr <= 1'b1;
    trig <= p;
    @(posedge pclk);
    clr <= 1'b0;
    trig <= 8'h00;
    repeat (5) @(posedge pclk);
  endtask
  task t_reset;
    rdres("mask", 12'h000, 16'h00FF);
    rdres("interval", 12'h004, 16'h0000);
    apb(1'b0, 12'h00C, 32'h0);
    chk("status_off", rd[15:0], 16'h0000);
  endtask
  // Masked arrival is kept, then served on unmask
  task t_latch;
    fire(8'h01);
    chk("held", 16'(seen), 16'h0000);
    cmd(12'h000, 12'h000, 16'h00FE, 1'b0);
    repeat (3) @(posedge pclk);
    chk("served", 16'(seen), 16'h0001);
    fire(8'h01);
    chk("direct", 16'(seen), 16'h0001);
  endtask
  // Clear drops only the selected latch
  task t_clear;
    fire(8'h06);
    cmd(12'h000, 12'h001, 16'h0002, 1'b0);
    cmd(12'h000, 12'h000, 16'h00F8, 1'b0);
    repeat (3) @(posedge pclk);
    chk("cleared", 16'(seen), 16'h0004);
  endtask
  // Mask-all keeps arrivals pending until unmask-all
  task t_all;
    cmd(12'h000, 12'h100, 16'h0000, 1'b0);
    fire(8'h02);
    chk("held_all", 16'(seen), 16'h0000);
    rdres("mask_all", 12'h000, 16'h00FF);
    cmd(12'h000, 12'h200, 16'h0000, 1'b0);
    repeat (3) @(posedge pclk);
    chk("after_all", 16'(seen), 16'h0002);
    rdres("mask_one", 12'h000, 16'h00F8);
  endtask
  // Wait-for-idle holds a request until the CPU is free
  task t_busy;
    apb(1'b1, 12'h010, 32'h0000_0002);
    cpu_busy <= 1'b1;
    fire(8'h01);
    chk("busy_hold", 16'(seen), 16'h0000);
    cpu_busy <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("idle_serve", 16'(seen), 16'h0001);
  endtask
  // Refused selectors and data, timer load, unmapped access
  task t_err;
    cmd(12'h003, 12'h000, 16'h0000, 1'b1);
    cmd(12'h000, 12'h003, 16'h0000, 1'b1);
    cmd(12'h004, 12'h000, 16'h00A0, 1'b1);
    cmd(12'h004, 12'h001, 16'h0001, 1'b0);
    cmd(12'h004, 12'h000, 16'h9999, 1'b0);
    rdres("interval", 12'h004, 16'h9999);
    apb(1'b0, 12'h018, 32'h0);
    chk("first_count", rd[15:0], 16'h0001);
    apb(1'b0, 12'h00C, 32'h0);
    chk("status_run", rd[15:0], 16'h0006);
    apb(1'b1, 12'h010, 32'h0000_0001);
    apb(1'b0, 12'h010, 32'h0);
    chk("setup", rd[15:0], 16'h0001);
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped", 16'(err), 16'h0001);
    chk("sched_early", 16'(sched_any), 16'h0000);
  endtask
  initial begin
    {presetn, psel, penable, pwrite, cpu_busy, clr} = 6'h01;
    paddr = 12'h000;
    pwdata = 32'h0;
    trig = 8'h00;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    clr <= 1'b0;
    t_reset;
    t_latch;
    t_clear;
    t_all;
    t_busy;
    t_err;
    complete_run;
  end
  // Tests need a few hundred cycles; this cuts a hang short
  initial begin
    #200000;
    n_mismatch++;
    complete_run;
  end
endmodule
